// file: tb/osct_monitor.sv
/*
  Port checker of the oscillator control block.
  Assumes it is bound into osct_top and that there is one clock domain.
*/
`timescale 1ns/10ps
module osct_monitor #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // requests
  input wire logic [5:0] module_request,
  input wire logic [2:0] new_source_request,
  // oscillator controls
  input wire logic ext_osc_run,
  input wire logic hf_osc_run,
  input wire logic [2:0] hf_freq_code,
  input wire logic [5:0] hf_nominal_mhz,
  input wire logic mf_osc_run,
  input wire logic lf_osc_run,
  input wire logic sec_osc_run,
  input wire logic conv_rc_osc_run
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire hf_src = new_source_request inside {3'h6, 3'h1, 3'h3, 3'h0};
  wire rd_done = psel && penable && pready && !pwrite;
  function automatic logic [5:0] mhz(input logic [2:0] c);
    case (c)
      3'h0: mhz = 6'h01;
      3'h1: mhz = 6'h02;
      3'h2: mhz = 6'h04;
      3'h3: mhz = 6'h08;
      3'h4: mhz = 6'h0c;
      3'h5: mhz = 6'h10;
      default: mhz = 6'h20;
    endcase
  endfunction : mhz
  property p_ext_req; module_request[5] |=> ext_osc_run; endproperty
  a_ext_req: assert property (p_ext_req) else $error("external run missed a request");
  property p_hf_req; module_request[4] || hf_src |=> hf_osc_run; endproperty
  a_hf_req: assert property (p_hf_req) else $error("hf run missed a request");
  property p_mf_req; module_request[3] |=> mf_osc_run; endproperty
  a_mf_req: assert property (p_mf_req) else $error("mf run missed a request");
  property p_lf_req; module_request[2] |=> lf_osc_run; endproperty
  a_lf_req: assert property (p_lf_req) else $error("lf run missed a request");
  property p_sec_req; module_request[1] |=> sec_osc_run; endproperty
  a_sec_req: assert property (p_sec_req) else $error("secondary run missed a request");
  property p_rc_req; module_request[0] |=> conv_rc_osc_run; endproperty
  a_rc_req: assert property (p_rc_req) else $error("rc run missed a request");
  property p_no_rsvd; hf_freq_code != 3'h7; endproperty
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved code reached oscillator");
  property p_mhz; hf_nominal_mhz == mhz($past(hf_freq_code)); endproperty
  a_mhz: assert property (p_mhz) else $error("nominal frequency does not match code");
  property p_force_rd; rd_done && paddr == 8'h00 |-> prdata[1:0] == 2'h0; endproperty
  a_force_rd: assert property (p_force_rd) else $error("force low bits not zero");
  property p_freq_rd; rd_done && paddr == 8'h04 |-> prdata[7:3] == 5'h00; endproperty
  a_freq_rd: assert property (p_freq_rd) else $error("select upper bits not zero");
  property p_trim_rd; rd_done && paddr == 8'h08 |-> prdata[7:6] == 2'h0; endproperty
  a_trim_rd: assert property (p_trim_rd) else $error("trim upper bits not zero");
  c_err: cover property (pslverr);
  c_hf: cover property (hf_src ##1 hf_osc_run);
  c_rd: cover property (rd_done);
endmodule : osct_monitor
bind osct_top osct_monitor #(.ADDR_W(ADDR_W)) osct_monitor_inst (.core_clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .module_request, .new_source_request, .ext_osc_run, .hf_osc_run,
  .hf_freq_code, .hf_nominal_mhz, .mf_osc_run, .lf_osc_run, .sec_osc_run, .conv_rc_osc_run);

// file: tb/tb_top.sv
/*
  Self-checking bench of the oscillator control block.
  Assumes the APB slave answers with pready and the straps stay static.
*/
`timescale 1ns/10ps
module tb_top;
  import osct_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} osct_row_t;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, er, ext_osc_run, hf_osc_run, mf_osc_run, lf_osc_run, sec_osc_run, conv_rc_osc_run;
  logic sec_osc_high_power;
  logic [2:0] reset_oscillator_config = 3'h6, external_osc_mode_config = 3'h5, ext_osc_mode, hf_freq_code;
  logic [2:0] new_source_request = 3'h5;
  logic [5:0] module_request = 6'h00, hf_nominal_mhz, hf_trim;
  int failures = 0, tests_run = 0, cyc = 0;
  wire [5:0] runs = {ext_osc_run, hf_osc_run, mf_osc_run, lf_osc_run, sec_osc_run, conv_rc_osc_run};
  logic [5:0] mhz_tab [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20};
  osct_row_t rows [5] = '{'{8'h00, 32'hff, 32'hfc, 0}, '{8'h04, 32'hff, 32'h07, 0}, '{8'h08, 32'hff, 32'h3f, 0},
    '{8'h0c, 32'h01, 32'h01, 0}, '{8'h20, 32'hff, 32'h00, 1}};
  osct_top osct_top_inst (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .reset_oscillator_config, .external_osc_mode_config, .module_request,
    .new_source_request, .ext_osc_run, .ext_osc_mode, .hf_osc_run, .hf_freq_code, .hf_nominal_mhz, .hf_trim,
    .mf_osc_run, .lf_osc_run, .sec_osc_run, .sec_osc_high_power, .conv_rc_osc_run);
  always #2.5 core_clk = ~core_clk;
  task close_out;
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_clk
  task do_reset(input logic [2:0] cfg);
    @(posedge core_clk);
    rst_n <= 0;
    reset_oscillator_config <= cfg;
    wait_clk(10);
    rst_n <= 1;
    wait_clk(8);
  endtask : do_reset
  initial begin
    do_reset(3'h6);
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      chk("write err", rows[i].e, er);
      apb(0, rows[i].a, 0);
      chk("read err", rows[i].e, er);
      chk("readback", rows[i].r, rd);
    end
    chk("sec power", 1, sec_osc_high_power);
    do_reset(3'h6);
    apb(0, 8'h00, 0);
    chk("force reset", 0, rd);
    apb(0, 8'h08, 0);
    chk("trim reset", 0, rd);
    apb(0, 8'h04, 0);
    chk("select reset 110", 2, rd);
    chk("ext mode", 5, ext_osc_mode);
    for (int i = 2; i < 8; i++) begin
      apb(1, 8'h00, 1 << i);
      wait_clk(3);
      chk("runs", 6'h01 << (i - 2), runs);
    end
    apb(1, 8'h00, 0);
    for (int c = 0; c < 7; c++) begin
      apb(1, 8'h04, c);
      wait_clk(3);
      chk("freq code", c, hf_freq_code);
      chk("freq mhz", mhz_tab[c], hf_nominal_mhz);
    end
    apb(1, 8'h04, 7);
    wait_clk(3);
    chk("reserved kept", 6, hf_freq_code);
    apb(0, 8'h14, 0);
    chk("status word", 32'h1656, rd);
    apb(1, 8'h08, 8'h20);
    wait_clk(3);
    chk("trim min", 6'h20, hf_trim);
    apb(1, 8'h08, 8'h1f);
    wait_clk(3);
    chk("trim max", 6'h1f, hf_trim);
    pstrb <= 4'he;
    apb(1, 8'h08, 8'h00);
    pstrb <= 4'hf;
    apb(0, 8'h08, 0);
    chk("strobe off", 32'h1f, rd);
    apb(1, 8'h10, 8'hff);
    chk("ro write err", 1, er);
    module_request <= 6'h2d;
    new_source_request <= 3'h6;
    wait_clk(3);
    chk("requests", 6'h3d, runs);
    apb(0, 8'h10, 0);
    chk("run status", 32'hf4, rd);
    module_request <= 6'h12;
    new_source_request <= 3'h3;
    wait_clk(3);
    chk("hf and sec requests", 6'h12, runs);
    module_request <= 6'h00;
    new_source_request <= 3'h1;
    wait_clk(3);
    chk("pll source", 6'h10, runs);
    new_source_request <= 3'h0;
    wait_clk(3);
    chk("alias source", 6'h10, runs);
    module_request <= 6'h00;
    new_source_request <= 3'h5;
    wait_clk(3);
    chk("released", 0, runs);
    do_reset(3'h0);
    apb(0, 8'h04, 0);
    chk("select reset 000", 6, rd);
    chk("code reset 000", 6, hf_freq_code);
    chk("mhz reset 000", 6'h20, hf_nominal_mhz);
    chk("sec power reset", 0, sec_osc_high_power);
    close_out();
  end
endmodule : tb_top

// file: verilog/osct_defines.svh
/*
  Register offsets, field positions, reset values and encodings of the
  oscillator control block. Assumes byte addresses on a 32-bit APB.
*/
`ifndef OSCT_DEFINES_SVH
`define OSCT_DEFINES_SVH

// register byte offsets
`define OSCT_ADDR_FORCE 8'h00
`define OSCT_ADDR_FREQ 8'h04
`define OSCT_ADDR_TRIM 8'h08
`define OSCT_ADDR_SECPWR 8'h0c
`define OSCT_ADDR_RUN 8'h10
`define OSCT_ADDR_CFG 8'h14

// force enable register: six force bits at [7:2], [1:0] unimplemented
`define OSCT_FORCE_LSB 2
`define OSCT_FORCE_MSB 7
`define OSCT_FORCE_RESET 6'h00
`define OSCT_IDX_RC 0
`define OSCT_IDX_SEC 1
`define OSCT_IDX_LF 2
`define OSCT_IDX_MF 3
`define OSCT_IDX_HF 4
`define OSCT_IDX_EXT 5

// frequency select field codes
`define OSCT_FRQ_1 3'h0
`define OSCT_FRQ_2 3'h1
`define OSCT_FRQ_4 3'h2
`define OSCT_FRQ_8 3'h3
`define OSCT_FRQ_12 3'h4
`define OSCT_FRQ_16 3'h5
`define OSCT_FRQ_32 3'h6
`define OSCT_FRQ_RSVD 3'h7
`define OSCT_FRQ_RESET 3'h2

// reset oscillator configuration codes
`define OSCT_RSTCFG_HF1 3'h6
`define OSCT_RSTCFG_HF32 3'h0

// new source request codes that run the high-frequency oscillator
`define OSCT_SRC_HF 3'h6
`define OSCT_SRC_HF_PLL 3'h1
`define OSCT_SRC_ALIAS_A 3'h3
`define OSCT_SRC_ALIAS_B 3'h0

// trim field and secondary power reset values
`define OSCT_TRIM_RESET 6'h00
`define OSCT_SECPWR_RESET 1'b0

// edges a strap needs through the synchroniser
`define OSCT_SYNC_CYCLES 2'd2

`endif

// file: verilog/osct_freq_ctl.sv
/*
  Effective frequency and trim of the high-frequency internal oscillator.
  Assumes select code and trim come from registers on the same clock.
*/
`timescale 1ns/10ps
`include "osct_defines.svh"

module osct_freq_ctl
  import osct_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // from the register file
  input wire logic [2:0] sel_code,
  input wire logic [5:0] trim_code,
  // to the oscillator and the status register
  output logic [2:0] eff_code,
  output logic [5:0] nominal_mhz,
  output logic [5:0] trim_out,
  output logic reserved_held
);

  logic sel_reserved;
  logic [5:0] next_mhz;

  assign sel_reserved = (sel_code == `OSCT_FRQ_RSVD);

  always_comb begin
    next_mhz = 6'h04;
    case (eff_code)
      `OSCT_FRQ_1: next_mhz = 6'h01;
      `OSCT_FRQ_2: next_mhz = 6'h02;
      `OSCT_FRQ_4: next_mhz = 6'h04;
      `OSCT_FRQ_8: next_mhz = 6'h08;
      `OSCT_FRQ_12: next_mhz = 6'h0c;
      `OSCT_FRQ_16: next_mhz = 6'h10;
      `OSCT_FRQ_32: next_mhz = 6'h20;
      default: next_mhz = 6'h04;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      eff_code <= `OSCT_FRQ_RESET;
      nominal_mhz <= 6'h04;
      trim_out <= `OSCT_TRIM_RESET;
      reserved_held <= 1'b0;
    end else begin
      if (!sel_reserved) begin
        eff_code <= sel_code;
      end
      nominal_mhz <= next_mhz;
      trim_out <= trim_code;
      reserved_held <= sel_reserved;
    end
  end

endmodule : osct_freq_ctl

// file: verilog/osct_pkg.sv
/*
  Types of the oscillator control block.
  Assumes nothing of its surroundings.
*/
package osct_pkg;

  typedef enum logic [2:0] {
    OSCT_SYNC = 3'b001,
    OSCT_LOAD = 3'b010,
    OSCT_READY = 3'b100
  } osct_init_t;

endpackage : osct_pkg

// file: verilog/osct_top.sv
/*
  Oscillator force-on, frequency select and trim control with an APB slave.
  Assumes one 200 MHz core_clk, straps that are static pins, and module
  requests and the new source request driven on core_clk.
*/
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "osct_defines.svh"

module osct_top
  import osct_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration straps (pins)
  input wire logic [2:0] reset_oscillator_config,
  input wire logic [2:0] external_osc_mode_config,
  // requests from other modules, same clock: one bit per oscillator, plus a 3-bit new source code
  input wire logic [5:0] module_request,
  input wire logic [2:0] new_source_request,
  // oscillator controls
  output logic ext_osc_run,
  output logic [2:0] ext_osc_mode,
  output logic hf_osc_run,
  output logic [2:0] hf_freq_code,
  output logic [5:0] hf_nominal_mhz,
  output logic [5:0] hf_trim,
  output logic mf_osc_run,
  output logic lf_osc_run,
  output logic sec_osc_run,
  output logic sec_osc_high_power,
  output logic conv_rc_osc_run
);

  // strap synchronisers
  logic [5:0] strap_meta;
  logic [5:0] strap_sync;
  logic [5:0] strap_pins;

  assign strap_pins = {external_osc_mode_config, reset_oscillator_config};

  genvar gs;
  generate
    for (gs = 0; gs < 6; gs++) begin : g_strap
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          strap_meta[gs] <= 1'b0;
          strap_sync[gs] <= 1'b0;
        end else begin
          strap_meta[gs] <= strap_pins[gs];
          strap_sync[gs] <= strap_meta[gs];
        end
      end
    end
  endgenerate

  // start-up sequence: wait for straps, then load defaults
  osct_init_t init_state;
  osct_init_t next_init_state;
  logic [1:0] sync_cnt;
  logic [1:0] next_sync_cnt;
  logic init_load;
  logic init_ready;

  assign init_load = (init_state == OSCT_LOAD);
  assign init_ready = (init_state == OSCT_READY);

  always_comb begin
    next_init_state = init_state;
    next_sync_cnt = sync_cnt;
    case (init_state)
      OSCT_SYNC: begin
        next_sync_cnt = sync_cnt + 2'd1;
        if (sync_cnt == `OSCT_SYNC_CYCLES) begin
          next_init_state = OSCT_LOAD;
        end
      end
      OSCT_LOAD: begin
        next_init_state = OSCT_READY;
      end
      OSCT_READY: begin
        next_init_state = OSCT_READY;
      end
      default: begin
        next_init_state = OSCT_SYNC;
        next_sync_cnt = 2'd0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_state <= OSCT_SYNC;
      sync_cnt <= 2'd0;
    end else begin
      init_state <= next_init_state;
      sync_cnt <= next_sync_cnt;
    end
  end

  // straps caught once after release
  logic [2:0] rst_cfg;
  logic [2:0] ext_mode_cfg;
  logic [2:0] strap_freq;

  assign strap_freq = (strap_sync[2:0] == `OSCT_RSTCFG_HF1) ? `OSCT_FRQ_4 :
                      (strap_sync[2:0] == `OSCT_RSTCFG_HF32) ? `OSCT_FRQ_32 :
                      `OSCT_FRQ_RESET;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cfg <= 3'h0;
      ext_mode_cfg <= 3'h0;
    end else if (init_load) begin
      rst_cfg <= strap_sync[2:0];
      ext_mode_cfg <= strap_sync[5:3];
    end
  end

  // apb decode
  logic apb_access;
  logic apb_done;
  logic apb_wr;
  logic lane0;
  logic hit_force;
  logic hit_freq;
  logic hit_trim;
  logic hit_secpwr;
  logic hit_run;
  logic hit_cfg;
  logic hit_any;
  logic hit_ro;
  logic [7:0] addr8;

  assign addr8 = paddr[7:0];
  assign apb_access = psel && penable && init_ready;
  assign apb_done = apb_access && pready;
  assign apb_wr = apb_done && pwrite && !pslverr;
  assign lane0 = pstrb[0];
  assign hit_force = (addr8 == `OSCT_ADDR_FORCE);
  assign hit_freq = (addr8 == `OSCT_ADDR_FREQ);
  assign hit_trim = (addr8 == `OSCT_ADDR_TRIM);
  assign hit_secpwr = (addr8 == `OSCT_ADDR_SECPWR);
  assign hit_run = (addr8 == `OSCT_ADDR_RUN);
  assign hit_cfg = (addr8 == `OSCT_ADDR_CFG);
  assign hit_ro = hit_run || hit_cfg;
  assign hit_any = hit_force || hit_freq || hit_trim || hit_secpwr || hit_ro;

  // per-register write strobes
  logic wr_force;
  logic wr_freq;
  logic wr_trim;
  logic wr_secpwr;

  assign wr_force = apb_wr && lane0 && hit_force;
  assign wr_freq = apb_wr && lane0 && hit_freq;
  assign wr_trim = apb_wr && lane0 && hit_trim;
  assign wr_secpwr = apb_wr && lane0 && hit_secpwr;

  // software registers
  logic [5:0] force_on;
  logic [2:0] freq_sel;
  logic [5:0] trim_field;
  logic sec_pwr;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      force_on <= `OSCT_FORCE_RESET;
    end else if (wr_force) begin
      force_on <= pwdata[`OSCT_FORCE_MSB:`OSCT_FORCE_LSB];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_sel <= `OSCT_FRQ_RESET;
    end else if (init_load) begin
      freq_sel <= strap_freq;
    end else if (wr_freq) begin
      freq_sel <= pwdata[2:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_field <= `OSCT_TRIM_RESET;
    end else if (wr_trim) begin
      trim_field <= pwdata[5:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_pwr <= `OSCT_SECPWR_RESET;
    end else if (wr_secpwr) begin
      sec_pwr <= pwdata[0];
    end
  end

  // high-frequency oscillator wanted by the new source request
  logic hf_by_source;
  logic src_hf_direct;
  logic src_hf_alias;

  // reserved request codes behave as the plain high-frequency request
  assign src_hf_direct = (new_source_request == `OSCT_SRC_HF) || (new_source_request == `OSCT_SRC_HF_PLL);
  assign src_hf_alias = (new_source_request == `OSCT_SRC_ALIAS_A) || (new_source_request == `OSCT_SRC_ALIAS_B);
  assign hf_by_source = src_hf_direct || src_hf_alias;

  // per-oscillator run: force bit or any other requester
  logic [5:0] extra_req;
  logic [5:0] run_req;
  logic [5:0] run;

  assign extra_req = {1'b0, hf_by_source, 4'h0};
  assign run_req = force_on | module_request | extra_req;

  genvar go;
  generate
    for (go = 0; go < 6; go++) begin : g_run
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          run[go] <= 1'b0;
        end else begin
          run[go] <= run_req[go];
        end
      end
    end
  endgenerate

  assign ext_osc_run = run[`OSCT_IDX_EXT];
  assign hf_osc_run = run[`OSCT_IDX_HF];
  assign mf_osc_run = run[`OSCT_IDX_MF];
  assign lf_osc_run = run[`OSCT_IDX_LF];
  assign sec_osc_run = run[`OSCT_IDX_SEC];
  assign conv_rc_osc_run = run[`OSCT_IDX_RC];

  // mode outputs, registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_osc_mode <= 3'h0;
      sec_osc_high_power <= 1'b0;
    end else begin
      ext_osc_mode <= ext_mode_cfg;
      sec_osc_high_power <= sec_pwr;
    end
  end

  // frequency and trim path
  logic reserved_held;

  osct_freq_ctl u_freq (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sel_code(freq_sel),
    .trim_code(trim_field),
    .eff_code(hf_freq_code),
    .nominal_mhz(hf_nominal_mhz),
    .trim_out(hf_trim),
    .reserved_held(reserved_held)
  );

  // read mux
  logic [31:0] rd_force;
  logic [31:0] rd_freq;
  logic [31:0] rd_trim;
  logic [31:0] rd_secpwr;
  logic [31:0] rd_run;
  logic [31:0] rd_cfg;
  logic [31:0] rd_word;

  assign rd_force = {24'h0, force_on, 2'b00};
  assign rd_freq = {29'h0, freq_sel};
  assign rd_trim = {26'h0, trim_field};
  assign rd_secpwr = {31'h0, sec_pwr};
  assign rd_run = {24'h0, run, 2'b00};
  assign rd_cfg = {19'h0, reserved_held, 1'b0, hf_freq_code, 1'b0, ext_mode_cfg, 1'b0, rst_cfg};

  assign rd_word = hit_force ? rd_force :
                   hit_freq ? rd_freq :
                   hit_trim ? rd_trim :
                   hit_secpwr ? rd_secpwr :
                   hit_run ? rd_run :
                   hit_cfg ? rd_cfg :
                   32'h0;

  // apb answer: one wait state, then pready for one cycle
  logic next_pready;
  logic next_pslverr;
  logic bad_addr;
  logic ro_write;

  // refused: unmapped address, or a write to a status register
  assign bad_addr = !hit_any;
  assign ro_write = pwrite && hit_ro;

  assign next_pready = apb_access && !pready;
  assign next_pslverr = apb_access && !pready && (bad_addr || ro_write);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      if (next_pready && !pwrite) begin
        prdata <= rd_word;
      end else if (apb_done) begin
        prdata <= 32'h0;
      end
    end
  end

endmodule : osct_top
